// [dmx_map_params.svh]
/*
  Named constants for the douser and focus channel map: slot ranges, setting codes,
  reset values and the fixed-point figures used by the response curve and rescaling.
  Assumes it is included by bare name from the package and from each design file.
*/
`ifndef DMX_MAP_PARAMS_SVH
`define DMX_MAP_PARAMS_SVH

// ****************************************************************************
// Slot addressing
// ****************************************************************************
`define SLOT_OFFSET_MAX 5'h17
`define SLOT_STEP 10'h001
`define FIXTURE_NUMBER_FIRST 10'h001

// ****************************************************************************
// Setting codes
// ****************************************************************************
`define SLOT_WIDTH_TWO 2'h2
`define COMM_DMX_RECEIVE 2'h0
`define LOSS_RETURN_HOME 1'b0

// ****************************************************************************
// Reset values
// ****************************************************************************
`define POSITION_RESET 16'h0000
`define RATE_RESET 8'h00
`define SLOT_ADDR_RESET 10'h001

// ****************************************************************************
// Fixed-point figures
// ****************************************************************************
`define CURVE_THREE 18'h3_0000
`define FRACTION_TOP 31
`define FRACTION_LOW 16

`endif

// [dmx_map_pkg.sv]
/*
  Types shared by the channel map: axis sequencing states and the setting encodings.
  Assumes the constants header is available on the include path.
*/
`include "dmx_map_params.svh"

package dmx_map_pkg;

  typedef enum logic [1:0] {
    AXIS_WAIT_CAL = 2'b00,
    AXIS_HOME = 2'b01,
    AXIS_TRACK = 2'b10
  } axis_state_type;

  typedef enum logic {
    ORDER_HIGH_LOW = 1'b0,
    ORDER_LOW_HIGH = 1'b1
  } byte_order_type;

  typedef enum logic {
    POLICY_CLIP = 1'b0,
    POLICY_SCALE = 1'b1
  } limit_policy_type;

endpackage

// [level_shaper.sv]
/*
  Combinational shaping of one axis command: assembles one or two slots into a
  16-bit level, applies the optional cosine-shaped curve, then clips or rescales
  it against the axis lower and upper limits.
  Assumes the caller registers the result; nothing here holds state.
*/
`timescale 1ns/100ps
`default_nettype none

`include "dmx_map_params.svh"

module level_shaper
  import dmx_map_pkg::*;
(
  // Captured slots
  input wire logic [7:0] first_in,
  input wire logic [7:0] second_in,
  // Settings
  input wire logic wide_in,
  input wire logic order_in,
  input wire logic curve_in,
  input wire logic policy_in,
  input wire logic [15:0] lower_in,
  input wire logic [15:0] upper_in,
  // Result
  output logic [15:0] level_out,
  output logic accept_out
);

  logic [15:0] raw;
  logic [15:0] squared;
  logic [17:0] weight;
  logic [33:0] cubic;
  logic [15:0] shaped;
  logic [15:0] span;
  logic [32:0] scaled;

  always_comb begin
    if (wide_in) begin
      if (order_in == ORDER_LOW_HIGH) begin
        raw = {second_in, first_in};
      end else begin
        raw = {first_in, second_in};
      end
    end else begin
      // Replicating the byte makes 8'hFF land exactly on full scale.
      raw = {first_in, first_in};
    end
  end

  // Smoothstep stands in for the cosine fade, no table: zero maps to zero and 16'hffff maps to 16'hffff.
  always_comb begin
    squared = 16'((32'(raw) * 32'(raw)) >> `FRACTION_LOW);
    weight = `CURVE_THREE - {1'b0, raw, 1'b0};
    cubic = 34'(squared) * 34'(weight);
    shaped = curve_in ? cubic[`FRACTION_TOP:`FRACTION_LOW] : raw;
  end

  always_comb begin
    span = (upper_in > lower_in) ? (upper_in - lower_in) : 16'h0000;
    scaled = 33'(shaped) * 33'(span) + 33'(span);
    if (policy_in == POLICY_SCALE) begin
      level_out = lower_in + scaled[`FRACTION_TOP:`FRACTION_LOW];
      accept_out = 1'b1;
    end else begin
      level_out = shaped;
      accept_out = (shaped >= lower_in) && (shaped <= upper_in);
    end
  end

endmodule
`default_nettype wire

// [dmx_douser_focus_channel_map.sv]
/*
  Receive-side channel map for the douser and focus axes of a DMX512 fixture.
  Picks each axis's position and speed slots out of the incoming slot stream,
  shapes and limits the command, and sequences default positions around
  calibration and loss of signal.
  Assumes a DMX receiver upstream delivers one slot per SLOT_VALID_IN pulse with its
  slot number (1 to 512), a FRAME_DONE_IN pulse after the last slot of a frame, and
  a SIGNAL_LOST_IN level; all inputs are synchronous to MCLK_IN.
*/
`timescale 1ns/100ps
`default_nettype none

`include "dmx_map_params.svh"

// Behaviour
// - Each axis position slot sits 0 to 23 slots past the start address.
// - Each axis speed slot sits at its own offset, 0 to 23 slots.
// - Width 1 takes one 8-bit slot; width 2 joins two consecutive slots.
// - With two slots, byte order picks high-then-low or low-then-high.
// - Douser curve setting: 0 linear response, 1 cosine-shaped response.
// - Focus response setting: 0 follow behaviour, 1 speed-controlled behaviour.
// - Focus zero is full spot; full scale, 8 or 16 bit, is full flood.
// - Douser upper and lower limits bound its commanded travel.
// - Focus upper limit bounds travel toward flood.
// - Each axis chooses clipping or rescaling against its limits.
// - After calibration each axis goes home until the first valid command.
// - On data loss, if selected, an axis returns home.
// - Three communication types; only DMX receive acts on data.
// - By fixture number, start is (number minus one) times width plus one.
// - Stop key press raises the panel halt flag.
// - Clip mode ignores commands below the lower or above the upper limit.
// - Loss setting 0 returns axes home; 1 holds current position.
// - Focus lower limit bounds travel toward spot.

module dmx_douser_focus_channel_map
  import dmx_map_pkg::*;
#(
  parameter int AXES = 2
)
(
  // Clock and reset
  input wire logic MCLK_IN,
  input wire logic RESET_IN,
  // Slot stream from the DMX receiver
  input wire logic SLOT_VALID_IN,
  input wire logic [9:0] SLOT_NUMBER_IN,
  input wire logic [7:0] SLOT_DATA_IN,
  input wire logic FRAME_DONE_IN,
  input wire logic SIGNAL_LOST_IN,
  // System
  input wire logic CALIBRATION_DONE_IN,
  input wire logic [1:0] COMM_TYPE_IN,
  input wire logic PANEL_STOP_KEY_IN,
  input wire logic HALT_CLEAR_IN,
  input wire logic LOSS_HOLD_IN,
  // Addressing
  input wire logic BY_FIXTURE_IN,
  input wire logic [9:0] START_ADDRESS_IN,
  input wire logic [9:0] FIXTURE_NUMBER_IN,
  input wire logic [4:0] SLOTS_PER_UNIT_IN,
  // Douser settings
  input wire logic [4:0] SHUTTER_SLOT_OFFSET_IN,
  input wire logic [4:0] SHUTTER_RATE_SLOT_OFFSET_IN,
  input wire logic [1:0] SHUTTER_SLOT_WIDTH_IN,
  input wire logic SHUTTER_BYTE_ORDER_IN,
  input wire logic SHUTTER_RESPONSE_CURVE_IN,
  input wire logic SHUTTER_LIMIT_POLICY_IN,
  input wire logic [15:0] SHUTTER_LOWER_LIMIT_IN,
  input wire logic [15:0] SHUTTER_UPPER_LIMIT_IN,
  input wire logic [15:0] SHUTTER_HOME_POSITION_IN,
  // Focus settings
  input wire logic [4:0] ZOOM_SLOT_OFFSET_IN,
  input wire logic [4:0] ZOOM_RATE_SLOT_OFFSET_IN,
  input wire logic [1:0] ZOOM_SLOT_WIDTH_IN,
  input wire logic ZOOM_BYTE_ORDER_IN,
  input wire logic ZOOM_RESPONSE_SELECT_IN,
  input wire logic ZOOM_LIMIT_POLICY_IN,
  input wire logic [15:0] ZOOM_LOWER_LIMIT_IN,
  input wire logic [15:0] ZOOM_UPPER_LIMIT_IN,
  input wire logic [15:0] ZOOM_HOME_POSITION_IN,
  // Axis commands
  output logic [15:0] SHUTTER_POSITION_OUT,
  output logic [7:0] SHUTTER_RATE_OUT,
  output logic [15:0] ZOOM_POSITION_OUT,
  output logic [7:0] ZOOM_RATE_OUT,
  output logic ZOOM_SPEED_MODE_OUT,
  output logic [1:0] AXIS_TRACKING_OUT,
  // Status
  output logic [9:0] START_SLOT_OUT,
  output logic PANEL_HALT_FLAG_OUT
);

  // ****************************************************************************
  // Per-axis settings gathered into arrays, axis 0 douser, axis 1 focus
  // ****************************************************************************
  logic [4:0] pos_offset [AXES];
  logic [4:0] rate_offset [AXES];
  logic wide [AXES];
  logic order [AXES];
  logic curve [AXES];
  logic policy [AXES];
  logic [15:0] lower [AXES];
  logic [15:0] upper [AXES];
  logic [15:0] home [AXES];
  logic [15:0] position_r [AXES];
  logic [7:0] rate_r [AXES];
  logic [AXES-1:0] tracking;

  assign pos_offset[0] = SHUTTER_SLOT_OFFSET_IN;
  assign pos_offset[1] = ZOOM_SLOT_OFFSET_IN;
  assign rate_offset[0] = SHUTTER_RATE_SLOT_OFFSET_IN;
  assign rate_offset[1] = ZOOM_RATE_SLOT_OFFSET_IN;
  assign wide[0] = (SHUTTER_SLOT_WIDTH_IN == `SLOT_WIDTH_TWO);
  assign wide[1] = (ZOOM_SLOT_WIDTH_IN == `SLOT_WIDTH_TWO);
  assign order[0] = SHUTTER_BYTE_ORDER_IN;
  assign order[1] = ZOOM_BYTE_ORDER_IN;
  // The focus axis has no fade curve: zero is spot and full scale is flood as received.
  assign curve[0] = SHUTTER_RESPONSE_CURVE_IN;
  assign curve[1] = 1'b0;
  assign policy[0] = SHUTTER_LIMIT_POLICY_IN;
  assign policy[1] = ZOOM_LIMIT_POLICY_IN;
  assign lower[0] = SHUTTER_LOWER_LIMIT_IN;
  assign lower[1] = ZOOM_LOWER_LIMIT_IN;
  assign upper[0] = SHUTTER_UPPER_LIMIT_IN;
  assign upper[1] = ZOOM_UPPER_LIMIT_IN;
  assign home[0] = SHUTTER_HOME_POSITION_IN;
  assign home[1] = ZOOM_HOME_POSITION_IN;

  // ****************************************************************************
  // Start address and receive gating
  // ****************************************************************************
  logic [9:0] start_r;
  logic [14:0] unit_product;
  logic receiving;

  assign unit_product = 15'(FIXTURE_NUMBER_IN - `FIXTURE_NUMBER_FIRST) * 15'(SLOTS_PER_UNIT_IN);
  // Both bidirectional choices leave the map deaf to incoming data.
  assign receiving = (COMM_TYPE_IN == `COMM_DMX_RECEIVE);

  always_ff @(posedge MCLK_IN) begin
    if (RESET_IN) begin
      start_r <= `SLOT_ADDR_RESET;
    end else if (BY_FIXTURE_IN) begin
      start_r <= unit_product[9:0] + `SLOT_STEP;
    end else begin
      start_r <= START_ADDRESS_IN;
    end
  end

  // ****************************************************************************
  // Halt indication
  // ****************************************************************************
  // A key press in the same cycle as a clear keeps the flag set.
  always_ff @(posedge MCLK_IN) begin
    if (RESET_IN) begin
      PANEL_HALT_FLAG_OUT <= 1'b0;
    end else if (PANEL_STOP_KEY_IN) begin
      PANEL_HALT_FLAG_OUT <= 1'b1;
    end else if (HALT_CLEAR_IN) begin
      PANEL_HALT_FLAG_OUT <= 1'b0;
    end
  end

  // ****************************************************************************
  // Per-axis capture, shaping and sequencing
  // ****************************************************************************
  genvar a;
  generate
    for (a = 0; a < AXES; a++) begin : g_axis
      logic [4:0] pos_off_sat;
      logic [4:0] rate_off_sat;
      logic [9:0] pos_slot;
      logic [9:0] pos_next_slot;
      logic [9:0] rate_slot;
      logic [7:0] first_r;
      logic [7:0] second_r;
      logic [7:0] rate_byte_r;
      logic got_first_r;
      logic got_second_r;
      logic got_rate_r;
      logic frame_ok;
      logic [15:0] level;
      logic accept;
      axis_state_type state_r;

      // Offsets past the documented range saturate rather than wander.
      assign pos_off_sat = (pos_offset[a] > `SLOT_OFFSET_MAX) ? `SLOT_OFFSET_MAX : pos_offset[a];
      assign rate_off_sat = (rate_offset[a] > `SLOT_OFFSET_MAX) ? `SLOT_OFFSET_MAX : rate_offset[a];
      assign pos_slot = start_r + 10'(pos_off_sat);
      assign pos_next_slot = pos_slot + `SLOT_STEP;
      assign rate_slot = start_r + 10'(rate_off_sat);

      always_ff @(posedge MCLK_IN) begin
        if (RESET_IN || FRAME_DONE_IN) begin
          got_first_r <= 1'b0;
          got_second_r <= 1'b0;
          got_rate_r <= 1'b0;
        end else if (SLOT_VALID_IN && receiving) begin
          if (SLOT_NUMBER_IN == pos_slot) begin
            got_first_r <= 1'b1;
          end
          if (SLOT_NUMBER_IN == pos_next_slot) begin
            got_second_r <= 1'b1;
          end
          if (SLOT_NUMBER_IN == rate_slot) begin
            got_rate_r <= 1'b1;
          end
        end
      end

      always_ff @(posedge MCLK_IN) begin
        if (RESET_IN) begin
          first_r <= `RATE_RESET;
          second_r <= `RATE_RESET;
          rate_byte_r <= `RATE_RESET;
        end else if (SLOT_VALID_IN && receiving) begin
          if (SLOT_NUMBER_IN == pos_slot) begin
            first_r <= SLOT_DATA_IN;
          end
          if (SLOT_NUMBER_IN == pos_next_slot) begin
            second_r <= SLOT_DATA_IN;
          end
          if (SLOT_NUMBER_IN == rate_slot) begin
            rate_byte_r <= SLOT_DATA_IN;
          end
        end
      end

      // A command counts only when every slot that the width needs arrived in this frame.
      assign frame_ok = FRAME_DONE_IN && receiving && !SIGNAL_LOST_IN && got_first_r &&
                        (got_second_r || !wide[a]);

      level_shaper u_shaper (
        .first_in(first_r),
        .second_in(second_r),
        .wide_in(wide[a]),
        .order_in(order[a]),
        .curve_in(curve[a]),
        .policy_in(policy[a]),
        .lower_in(lower[a]),
        .upper_in(upper[a]),
        .level_out(level),
        .accept_out(accept)
      );

      always_ff @(posedge MCLK_IN) begin
        if (RESET_IN) begin
          state_r <= AXIS_WAIT_CAL;
          position_r[a] <= `POSITION_RESET;
        end else if (!CALIBRATION_DONE_IN) begin
          state_r <= AXIS_WAIT_CAL;
        end else begin
          case (state_r)
            AXIS_WAIT_CAL: begin
              state_r <= AXIS_HOME;
              position_r[a] <= home[a];
            end
            AXIS_HOME: begin
              if (frame_ok && accept) begin
                state_r <= AXIS_TRACK;
                position_r[a] <= level;
              end else begin
                position_r[a] <= home[a];
              end
            end
            AXIS_TRACK: begin
              if (SIGNAL_LOST_IN && LOSS_HOLD_IN == `LOSS_RETURN_HOME) begin
                state_r <= AXIS_HOME;
                position_r[a] <= home[a];
              end else if (frame_ok && accept) begin
                position_r[a] <= level;
              end
            end
            default: begin
              state_r <= AXIS_WAIT_CAL;
            end
          endcase
        end
      end

      always_ff @(posedge MCLK_IN) begin
        if (RESET_IN) begin
          rate_r[a] <= `RATE_RESET;
        end else if (frame_ok && got_rate_r) begin
          rate_r[a] <= rate_byte_r;
        end
      end

      assign tracking[a] = (state_r == AXIS_TRACK);
    end
  endgenerate

  // ****************************************************************************
  // Output registers
  // ****************************************************************************
  // Follow mode reports a zero rate so the motor stage tracks the level directly.
  always_ff @(posedge MCLK_IN) begin
    if (RESET_IN) begin
      SHUTTER_POSITION_OUT <= `POSITION_RESET;
      SHUTTER_RATE_OUT <= `RATE_RESET;
      ZOOM_POSITION_OUT <= `POSITION_RESET;
      ZOOM_RATE_OUT <= `RATE_RESET;
      ZOOM_SPEED_MODE_OUT <= 1'b0;
      AXIS_TRACKING_OUT <= 2'h0;
      START_SLOT_OUT <= `SLOT_ADDR_RESET;
    end else begin
      SHUTTER_POSITION_OUT <= position_r[0];
      SHUTTER_RATE_OUT <= rate_r[0];
      ZOOM_POSITION_OUT <= position_r[1];
      ZOOM_RATE_OUT <= ZOOM_RESPONSE_SELECT_IN ? rate_r[1] : `RATE_RESET;
      ZOOM_SPEED_MODE_OUT <= ZOOM_RESPONSE_SELECT_IN;
      AXIS_TRACKING_OUT <= tracking;
      START_SLOT_OUT <= start_r;
    end
  end

endmodule
`default_nettype wire

// [dmx_console_model.sv]
/*
  Console model: plays one frame of 24 slots from a start slot, then a frame-done pulse.
  Assumes the bench fills mem and calls send just after a rising clock edge.
*/
`timescale 1ns/100ps
`default_nettype none
module dmx_console_model (
  // Clock
  input wire logic clk_in,
  // Slot stream
  output logic slot_valid_out,
  output logic [9:0] slot_number_out,
  output logic [7:0] slot_data_out,
  output logic frame_done_out
);
  logic [7:0] mem [0:23];
  initial begin
    mem = '{default: 8'h00};
    slot_valid_out = 1'b0;
    slot_number_out = 10'h000;
    slot_data_out = 8'h00;
    frame_done_out = 1'b0;
  end
  task automatic send(input logic [9:0] start);
    for (int i = 0; i < 24; i++) begin
      @(posedge clk_in);
      #1;
      slot_valid_out = 1'b1;
      slot_number_out = start + 10'(i);
      slot_data_out = mem[i];
    end
    @(posedge clk_in);
    #1;
    // Released lines are inverted so a stale value is never mistaken for data.
    slot_valid_out = 1'b0;
    slot_data_out = ~slot_data_out;
    slot_number_out = ~slot_number_out;
    frame_done_out = 1'b1;
    @(posedge clk_in);
    #1;
    frame_done_out = 1'b0;
  endtask
endmodule
`default_nettype wire

// [dmx_map_asserts.sv]
/*
  Port-level assertions for the channel map.
  Assumes it is bound to the map's top module, all ports on one clock.
*/
`timescale 1ns/100ps
`default_nettype none
module dmx_map_asserts (
  input wire logic MCLK_IN,
  input wire logic RESET_IN,
  input wire logic SIGNAL_LOST_IN,
  input wire logic CALIBRATION_DONE_IN,
  input wire logic [1:0] COMM_TYPE_IN,
  input wire logic PANEL_STOP_KEY_IN,
  input wire logic HALT_CLEAR_IN,
  input wire logic LOSS_HOLD_IN,
  input wire logic BY_FIXTURE_IN,
  input wire logic [9:0] START_ADDRESS_IN,
  input wire logic [9:0] FIXTURE_NUMBER_IN,
  input wire logic [4:0] SLOTS_PER_UNIT_IN,
  input wire logic [15:0] SHUTTER_LOWER_LIMIT_IN,
  input wire logic [15:0] SHUTTER_UPPER_LIMIT_IN,
  input wire logic [15:0] SHUTTER_HOME_POSITION_IN,
  input wire logic [15:0] ZOOM_LOWER_LIMIT_IN,
  input wire logic [15:0] ZOOM_UPPER_LIMIT_IN,
  input wire logic [15:0] ZOOM_HOME_POSITION_IN,
  input wire logic [15:0] SHUTTER_POSITION_OUT,
  input wire logic [15:0] ZOOM_POSITION_OUT,
  input wire logic [7:0] ZOOM_RATE_OUT,
  input wire logic ZOOM_SPEED_MODE_OUT,
  input wire logic [1:0] AXIS_TRACKING_OUT,
  input wire logic [9:0] START_SLOT_OUT,
  input wire logic PANEL_HALT_FLAG_OUT
);
  logic [9:0] fix_start;
  assign fix_start = (FIXTURE_NUMBER_IN - 10'h001) * {5'h00, SLOTS_PER_UNIT_IN} + 10'h001;
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (RESET_IN);
  sequence s_addr_quiet;
    (!RESET_IN && $stable(BY_FIXTURE_IN) && $stable(START_ADDRESS_IN) && $stable(FIXTURE_NUMBER_IN)
      && $stable(SLOTS_PER_UNIT_IN))[*3];
  endsequence
  sequence s_off_air;
    (!RESET_IN && COMM_TYPE_IN != 2'h0 && CALIBRATION_DONE_IN && !SIGNAL_LOST_IN)[*4];
  endsequence
  sequence s_lost_hold;
    (!RESET_IN && SIGNAL_LOST_IN && LOSS_HOLD_IN && CALIBRATION_DONE_IN)[*4];
  endsequence
  a_start_direct: assert property (s_addr_quiet ##0 !BY_FIXTURE_IN |-> START_SLOT_OUT == START_ADDRESS_IN)
    else $error("start slot differs from start address");
  a_start_fixture: assert property (s_addr_quiet ##0 BY_FIXTURE_IN |-> START_SLOT_OUT == fix_start)
    else $error("start slot differs from fixture formula");
  a_halt_set: assert property (PANEL_STOP_KEY_IN |=> PANEL_HALT_FLAG_OUT)
    else $error("halt flag not raised by stop key");
  a_halt_sticky: assert property (PANEL_HALT_FLAG_OUT && !HALT_CLEAR_IN |=> PANEL_HALT_FLAG_OUT)
    else $error("halt flag dropped without clear");
  a_follow_rate: assert property (!ZOOM_SPEED_MODE_OUT |-> ZOOM_RATE_OUT == 8'h00)
    else $error("focus rate nonzero in follow mode");
  a_zoom_bounds: assert property (AXIS_TRACKING_OUT[1] && $changed(ZOOM_POSITION_OUT) &&
    ZOOM_LOWER_LIMIT_IN <= ZOOM_UPPER_LIMIT_IN |->
    ZOOM_POSITION_OUT inside {[ZOOM_LOWER_LIMIT_IN:ZOOM_UPPER_LIMIT_IN]})
    else $error("focus position outside limits");
  a_shutter_bounds: assert property (AXIS_TRACKING_OUT[0] && $changed(SHUTTER_POSITION_OUT) &&
    SHUTTER_LOWER_LIMIT_IN <= SHUTTER_UPPER_LIMIT_IN
    |-> SHUTTER_POSITION_OUT inside {[SHUTTER_LOWER_LIMIT_IN:SHUTTER_UPPER_LIMIT_IN]})
    else $error("douser position outside limits");
  a_comm_ignore: assert property (s_off_air |-> $stable(SHUTTER_POSITION_OUT) && $stable(ZOOM_POSITION_OUT))
    else $error("position moved with receive off");
  a_loss_home: assert property (AXIS_TRACKING_OUT[0] && SIGNAL_LOST_IN && !LOSS_HOLD_IN && CALIBRATION_DONE_IN
    |-> ##[1:3] SHUTTER_POSITION_OUT == SHUTTER_HOME_POSITION_IN)
    else $error("douser not home after loss");
  a_loss_hold: assert property (s_lost_hold |-> $stable(ZOOM_POSITION_OUT))
    else $error("focus moved while holding on loss");
  a_cal_home: assert property ($rose(CALIBRATION_DONE_IN) |-> ##[1:4] ZOOM_POSITION_OUT == ZOOM_HOME_POSITION_IN)
    else $error("focus not home after calibration");
endmodule
`default_nettype wire

// [dmx_douser_focus_channel_map_tb.sv]
/*
  Self-checking bench for the channel map.
  Assumes the console model drives the slot stream; settings are plain inputs.
*/
`timescale 1ns/100ps
`default_nettype none
module dmx_douser_focus_channel_map_tb;
  import dmx_map_pkg::*;
  // ****************************************************************************
  // Stimulus and observed signals
  // ****************************************************************************
  logic mclk = 1'b0, rst = 1'b1, lost = 1'b0, cal = 1'b0, key = 1'b0, clr = 1'b0, hold = 1'b0, by_fix = 1'b0;
  logic [1:0] comm = 2'h0, s_wid = 2'h2, z_wid = 2'h2;
  logic [9:0] addr = 10'h00a, fix_num = 10'h00a;
  logic [4:0] unit_w = 5'h0c;
  logic s_ord = 1'b0, s_curve = 1'b0, s_pol = 1'b1, z_ord = 1'b0, z_sel = 1'b1, z_pol = 1'b1;
  logic [15:0] s_lo = 16'h0000, s_hi = 16'hffff, s_home = 16'h1111;
  logic [15:0] z_lo = 16'h0000, z_hi = 16'hffff, z_home = 16'h2222;
  wire logic sv, fd;
  wire logic [9:0] sn, start_out;
  wire logic [7:0] sd, s_rate, z_rate;
  wire logic [15:0] s_pos, z_pos;
  wire logic z_mode, halt;
  wire logic [1:0] trk;
  int err_total = 0;
  int num_checks = 0;
  always #50 mclk = ~mclk;
  dmx_console_model dmx_console_model_i (.clk_in(mclk), .slot_valid_out(sv), .slot_number_out(sn),
    .slot_data_out(sd), .frame_done_out(fd));
  dmx_douser_focus_channel_map dmx_douser_focus_channel_map_i (.MCLK_IN(mclk), .RESET_IN(rst),
    .SLOT_VALID_IN(sv), .SLOT_NUMBER_IN(sn), .SLOT_DATA_IN(sd), .FRAME_DONE_IN(fd), .SIGNAL_LOST_IN(lost),
    .CALIBRATION_DONE_IN(cal), .COMM_TYPE_IN(comm), .PANEL_STOP_KEY_IN(key), .HALT_CLEAR_IN(clr),
    .LOSS_HOLD_IN(hold), .BY_FIXTURE_IN(by_fix), .START_ADDRESS_IN(addr), .FIXTURE_NUMBER_IN(fix_num),
    .SLOTS_PER_UNIT_IN(unit_w), .SHUTTER_SLOT_OFFSET_IN(5'h00), .SHUTTER_RATE_SLOT_OFFSET_IN(5'h02),
    .SHUTTER_SLOT_WIDTH_IN(s_wid), .SHUTTER_BYTE_ORDER_IN(s_ord), .SHUTTER_RESPONSE_CURVE_IN(s_curve),
    .SHUTTER_LIMIT_POLICY_IN(s_pol), .SHUTTER_LOWER_LIMIT_IN(s_lo), .SHUTTER_UPPER_LIMIT_IN(s_hi),
    .SHUTTER_HOME_POSITION_IN(s_home), .ZOOM_SLOT_OFFSET_IN(5'h03), .ZOOM_RATE_SLOT_OFFSET_IN(5'h05),
    .ZOOM_SLOT_WIDTH_IN(z_wid), .ZOOM_BYTE_ORDER_IN(z_ord), .ZOOM_RESPONSE_SELECT_IN(z_sel),
    .ZOOM_LIMIT_POLICY_IN(z_pol), .ZOOM_LOWER_LIMIT_IN(z_lo), .ZOOM_UPPER_LIMIT_IN(z_hi),
    .ZOOM_HOME_POSITION_IN(z_home), .SHUTTER_POSITION_OUT(s_pos), .SHUTTER_RATE_OUT(s_rate),
    .ZOOM_POSITION_OUT(z_pos), .ZOOM_RATE_OUT(z_rate), .ZOOM_SPEED_MODE_OUT(z_mode),
    .AXIS_TRACKING_OUT(trk), .START_SLOT_OUT(start_out), .PANEL_HALT_FLAG_OUT(halt));
  // ****************************************************************************
  // Tasks
  // ****************************************************************************
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic cmp(input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t expected %h got %h", $time, exp, got);
    end
  endtask
  // Outputs follow one edge after the frame-done edge, so two ticks suffice.
  task automatic frame(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c, input logic [7:0] d);
    dmx_console_model_i.mem[0] = a;
    dmx_console_model_i.mem[1] = b;
    dmx_console_model_i.mem[3] = c;
    dmx_console_model_i.mem[4] = d;
    dmx_console_model_i.send(10'h00a);
    tick(2);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ****************************************************************************
  // Tests
  // ****************************************************************************
  initial begin
    tick(16);
    // Filled after time zero so that the model's own initial clear cannot overwrite the speed slots.
    dmx_console_model_i.mem[2] = 8'h5a;
    dmx_console_model_i.mem[5] = 8'hc3;
    cmp(16'h0000, s_pos);
    cmp(16'h0001, {6'h00, start_out});
    rst = 1'b0;
    tick(3);
    cmp(16'h000a, {6'h00, start_out});
    cal = 1'b1;
    tick(4);
    cmp(16'h1111, s_pos);
    cmp(16'h2222, z_pos);
    cmp(16'h0000, {14'h0000, trk});
    $display("test reset and home done");
    frame(8'h12, 8'h34, 8'hab, 8'hcd);
    cmp(16'h1234, s_pos);
    cmp(16'habcd, z_pos);
    cmp(16'h0003, {14'h0000, trk});
    cmp(16'h005a, {8'h00, s_rate});
    cmp(16'h00c3, {8'h00, z_rate});
    s_ord = 1'b1;
    z_ord = 1'b1;
    frame(8'h12, 8'h34, 8'hab, 8'hcd);
    cmp(16'h3412, s_pos);
    cmp(16'hcdab, z_pos);
    z_wid = 2'h1;
    frame(8'h12, 8'h34, 8'hff, 8'h00);
    cmp(16'hffff, z_pos);
    frame(8'h12, 8'h34, 8'h00, 8'hff);
    cmp(16'h0000, z_pos);
    $display("test width and order done");
    s_ord = 1'b0;
    s_curve = 1'b1;
    frame(8'hff, 8'hff, 8'h00, 8'h00);
    cmp(16'hffff, s_pos);
    frame(8'h40, 8'h00, 8'h00, 8'h00);
    cmp(16'h0001, {15'h0000, (s_pos !== 16'h0000 && s_pos < 16'h4000)});
    $display("test curve done");
    z_wid = 2'h2;
    z_ord = 1'b0;
    z_pol = 1'b0;
    z_lo = 16'h1000;
    z_hi = 16'h8000;
    s_curve = 1'b0;
    s_pol = 1'b0;
    s_lo = 16'h1000;
    frame(8'h30, 8'h00, 8'h40, 8'h00);
    cmp(16'h3000, s_pos);
    cmp(16'h4000, z_pos);
    frame(8'h00, 8'h00, 8'h80, 8'h01);
    cmp(16'h4000, z_pos);
    frame(8'h00, 8'h00, 8'h0f, 8'hff);
    cmp(16'h4000, z_pos);
    frame(8'h00, 8'h00, 8'h80, 8'h00);
    cmp(16'h8000, z_pos);
    z_pol = 1'b1;
    z_hi = 16'h2000;
    frame(8'h00, 8'h00, 8'hff, 8'hff);
    cmp(16'h2000, z_pos);
    frame(8'h00, 8'h00, 8'h00, 8'h00);
    cmp(16'h1000, z_pos);
    z_sel = 1'b0;
    tick(3);
    cmp(16'h0000, {8'h00, z_rate});
    cmp(16'h0000, {15'h0000, z_mode});
    $display("test limits done");
    for (int k = 1; k < 4; k++) begin
      comm = 2'(k);
      frame(8'h77, 8'h77, 8'h18, 8'h00);
      cmp(16'h3000, s_pos);
      cmp(16'h1000, z_pos);
    end
    comm = 2'h0;
    hold = 1'b1;
    lost = 1'b1;
    frame(8'h66, 8'h66, 8'h18, 8'h00);
    cmp(16'h3000, s_pos);
    cmp(16'h1000, z_pos);
    lost = 1'b0;
    hold = 1'b0;
    frame(8'h55, 8'h55, 8'h00, 8'h00);
    lost = 1'b1;
    tick(4);
    cmp(16'h1111, s_pos);
    cmp(16'h2222, z_pos);
    lost = 1'b0;
    $display("test loss done");
    key = 1'b1;
    tick(2);
    key = 1'b0;
    tick(2);
    cmp(16'h0001, {15'h0000, halt});
    clr = 1'b1;
    tick(2);
    cmp(16'h0000, {15'h0000, halt});
    key = 1'b1;
    tick(2);
    cmp(16'h0001, {15'h0000, halt});
    key = 1'b0;
    by_fix = 1'b1;
    tick(4);
    cmp(16'h006d, {6'h00, start_out});
    $display("test halt and fixture done");
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    finish_test();
  end
endmodule
bind dmx_douser_focus_channel_map dmx_map_asserts dmx_map_asserts_i (.*);
`default_nettype wire
